// ===== bench/ebc_break_ctrl_assertions.sv
// Checker of halt, power-down, port timing and watchdog marker outputs.
// Bound to ebc_break_ctrl and sees only its ports.
`timescale 1ns/1ps
module ebc_break_ctrl_assertions
   import ebc_pkg::*;
(
   input logic                  clk,
   input logic                  nrst,
   input ebc_fetch_t            fetch,
   input logic [1:0]            tstate,
   input logic                  run_cmd,
   input logic                  out_wr,
   input logic [3:0]            other_wr_data,
   input logic                  halted,
   input logic [EBC_ADDR_W-1:0] halt_addr,
   input logic [EBC_ADDR_W-1:0] resume_addr,
   input logic                  timer_clk_en,
   input logic                  trace_event,
   input logic                  power_down,
   input logic                  watchdog_check_pin,
   input ebc_ports_t            emu_ports,
   input logic [3:0]            other_ports
);
   wire wd_f = fetch.valid && !fetch.skipped &&
               fetch.op == EBC_OP_WDT_RESTART;
   wire o_t2 = fetch.op == EBC_OP_OUTPUT && tstate == EBC_T2;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   timer_on_a: assert property (timer_clk_en)
      else $error("timer enable low");
   arm_inert_a: assert property (
      fetch.valid && fetch.op == EBC_OP_POWER_ARM && !run_cmd
      |=> $stable(power_down)) else $error("arm changed state");
   poff_a: assert property (
      fetch.valid && !fetch.skipped && fetch.op == EBC_OP_POWER_OFF
      && !halted |=> power_down) else $error("no power-down");
   halt_hold_a: assert property (halted && !run_cmd |=> halted)
      else $error("halt dropped");
   halt_at_a: assert property (
      $rose(halted) |-> $past(fetch.valid) &&
      halt_addr == $past(fetch.addr) && resume_addr == halt_addr)
      else $error("halt address wrong");
   wd_pin_a: assert property (wd_f |=> watchdog_check_pin)
      else $error("no check pulse");
   wd_cause_a: assert property (
      $rose(watchdog_check_pin) |-> $past(wd_f))
      else $error("stray check pulse");
   emu_time_a: assert property (!$stable(emu_ports) |-> $past(o_t2))
      else $error("emulated port early");
   other_a: assert property (
      out_wr |=> other_ports == $past(other_wr_data))
      else $error("other port late");
   trace_one_a: assert property (trace_event |=> !trace_event)
      else $error("trace pulse long");
endmodule
bind ebc_break_ctrl ebc_break_ctrl_assertions u_chk (.*);

// ===== bench/ebc_break_ctrl_tb.sv
// Testbench of the break control block with a host model.
// Assumes inputs change at the falling edge of a 40 MHz clock.
`timescale 1ns/1ps
module ebc_break_ctrl_tb;
   import ebc_pkg::*;
   logic        clk, nrst, run_cmd, force_break, trig_in, trig_rising;
   logic        trig_brk_en, out_wr, halted, hp, trace_event, power_down;
   logic        core_run, timer_clk_en, watchdog_check_pin;
   logic [1:0]  tstate;
   logic [3:0]  other_wr_data, other_ports, dly;
   logic [12:0] halt_addr, resume_addr, a, exp_q[$];
   ebc_fetch_t  fetch;
   ebc_ports_t  out_wr_data, emu_ports;
   int          error_cnt, checks_done, tr_cnt, cyc;
   integer      seed;
   ebc_break_ctrl uut (.*);
   ebc_host_model host (.clk(clk), .halted(halted),
      .power_down(power_down), .dly(dly), .run_cmd(run_cmd));
   assign tstate = (fetch.op == EBC_OP_OUTPUT) ? EBC_T2 : EBC_T1;
   always #12.5 clk = ~clk;
   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude;
      if (error_cnt == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic fe(logic [12:0] ad, ebc_op_t o, logic s, b, k);
      @(negedge clk);
      fetch = '{1'b1, ad, o, s, b};
      force_break = k;
      @(negedge clk);
      fetch = '0;
      force_break = 1'b0;
   endtask
   task automatic rel;
      wait (halted === 1'b1);
      chk("timer_clk_en", 16'(timer_clk_en), 16'h1);
      wait (halted === 1'b0);
      @(negedge clk);
   endtask
   always @(negedge clk) begin
      if (halted === 1'b1 && !hp && exp_q.size() > 0)
         chk("halt_addr", 16'(halt_addr), 16'(exp_q.pop_front()));
      else if (halted === 1'b1 && !hp)
         chk("halt", 16'h1, 16'h0);
      hp = (halted === 1'b1);
      if (trace_event === 1'b1)
         tr_cnt++;
      if (++cyc > 4000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      {clk, nrst, force_break, trig_in, out_wr, hp} = '0;
      {trig_rising, trig_brk_en, dly, fetch, other_wr_data} = '0;
      out_wr_data = '0;
      seed = 32'hc620;
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      a = 13'($random(seed));
      dly = 4'h1;
      exp_q.push_back(a + 13'h3);
      fe(a, EBC_OP_CONT, 0, 0, 0);
      fe(a + 13'h1, EBC_OP_CONT, 0, 1, 0);
      fe(a + 13'h2, EBC_OP_CONT, 0, 0, 0);
      fe(a + 13'h3, EBC_OP_OTHER, 0, 0, 0);
      rel();
      dly = 4'h6;
      exp_q.push_back(a + 13'h2);
      fe(a, EBC_OP_CONT, 0, 0, 0);
      fe(a + 13'h1, EBC_OP_CONT, 0, 0, 1);
      fe(a + 13'h2, EBC_OP_CONT, 0, 0, 0);
      rel();
      fe(a + 13'h3, EBC_OP_OTHER, 0, 0, 0);
      trig_brk_en = 1'b1;
      for (int r = 1; r >= 0; r--) begin
         trig_rising = r[0];
         trig_in = r[0];
         repeat (5) @(negedge clk);
         exp_q.push_back(a + 13'h5);
         fe(a + 13'h5, EBC_OP_CONT, 0, 0, 0);
         rel();
      end
      {trig_brk_en, trig_rising, trig_in} = 3'h3;
      repeat (5) @(negedge clk);
      fe(a + 13'h7, EBC_OP_OTHER, 1, 1, 0);
      fe(a + 13'h8, EBC_OP_OTHER, 0, 1, 0);
      exp_q.push_back(a + 13'h9);
      fe(a + 13'h9, EBC_OP_OTHER, 0, 0, 0);
      rel();
      out_wr_data = ebc_ports_t'(14'($random(seed)));
      other_wr_data = 4'($random(seed));
      out_wr = 1'b1;
      @(negedge clk);
      out_wr = 1'b0;
      chk("other_ports", 16'(other_ports), 16'(other_wr_data));
      chk("emu_ports", 16'(emu_ports), 16'h0);
      fe(a + 13'h9, EBC_OP_OUTPUT, 0, 0, 0);
      chk("emu_ports", 16'(emu_ports), 16'(out_wr_data));
      fe(a + 13'ha, EBC_OP_POWER_ARM, 0, 0, 0);
      chk("power_down", 16'(power_down), 16'h0);
      fe(a + 13'hb, EBC_OP_WDT_RESTART, 0, 0, 0);
      chk("check pin", 16'(watchdog_check_pin), 16'h1);
      fe(a + 13'hc, EBC_OP_POWER_OFF, 0, 0, 0);
      chk("power_down", 16'(power_down), 16'h1);
      chk("core_run", 16'(core_run), 16'h0);
      wait (power_down === 1'b0);
      chk("trace count", 16'(tr_cnt), 16'h3);
      conclude();
   end
endmodule

// ===== bench/ebc_host_model.sv
// Host model: answers each halt or power-down with a go command.
// Assumes the bench fetches the address past any run after resuming.
`timescale 1ns/1ps
module ebc_host_model (
   input  logic       clk,
   input  logic       halted,
   input  logic       power_down,
   input  logic [3:0] dly,
   output logic       run_cmd
);
   initial run_cmd = 1'b0;
   always @(posedge (halted | power_down)) begin
      repeat (dly) @(negedge clk);
      run_cmd = 1'b1;
      @(negedge clk);
      run_cmd = 1'b0;
   end
endmodule

// ===== src/ebc_break_ctrl.sv
// Break, run control and emulated port timing of the emulation board.
// Assumes a core that reports each fetch with its class, state T1..T3.
// Function
// - Hardware breakpoint inside continuous run halts at first address after run.
// - Forced or trigger break halts even inside a continuous run.
// - Such a break on the run's second instruction halts at the next one.
// - Internal clock and timer tick keep running while halted.
// - Emulated ports change at T2 of the next output instruction.
// - Other ports update with the real device timing.
// - Power-down is entered on the power-off instruction alone.
// - Power-off-arm instruction has no effect on any state.
// - Watchdog is inert; check pin pulses during each restart instruction that is not skipped.
// - Breakpoint on a skipped instruction does not halt.
// - Trigger break on selectable edge; same input for trace events.
`timescale 1ns/1ps
module ebc_break_ctrl
   import ebc_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire ebc_fetch_t            fetch,
   input  wire logic [1:0]            tstate,
   input  wire logic                  run_cmd,
   input  wire logic                  force_break,
   input  wire logic                  trig_in,
   input  wire logic                  trig_rising,
   input  wire logic                  trig_brk_en,
   input  wire logic                  out_wr,
   input  wire ebc_ports_t            out_wr_data,
   input  wire logic [3:0]            other_wr_data,
   output logic                       halted,
   output logic [EBC_ADDR_W-1:0]      halt_addr,
   output logic [EBC_ADDR_W-1:0]      resume_addr,
   output logic                       core_run,
   output logic                       timer_clk_en,
   output logic                       trace_event,
   output logic                       power_down,
   output logic                       watchdog_check_pin,
   output ebc_ports_t                 emu_ports,
   output logic [3:0]                 other_ports
);

   logic       rst_meta_reg;
   logic       rst_sync_reg;
   logic       nrst_s;
   logic       trig_meta_reg;
   logic       trig_sync_reg;
   logic       trig_prev_reg;
   logic       trig_meta_next;
   logic       trig_sync_next;
   logic       trig_prev_next;
   logic       trig_edge;

   // Run control states
   typedef enum logic [1:0] {
      EBC_RUN,
      EBC_PEND_ASYNC,
      EBC_PEND_HW,
      EBC_HALT
   } ebc_state_t;

   // Next-value pairs of each state group
   ebc_state_t             state_reg, state_next;
   logic [EBC_ADDR_W-1:0]  halt_reg, halt_next;
   logic [EBC_ADDR_W-1:0]  resume_reg, resume_next;
   logic                   pd_reg, pd_next;
   logic                   wdt_reg, wdt_next;
   ebc_ports_t             pend_reg, pend_next;
   ebc_ports_t             emu_reg, emu_next;
   logic [3:0]             oth_reg, oth_next;
   logic                   async_req;
   logic                   hw_req;

   // Reset release through two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign nrst_s = rst_sync_reg;

   // Trigger synchroniser and previous-value stage
   always_comb begin
      trig_meta_next = trig_in;
      trig_sync_next = trig_meta_reg;
      // Third stage holds the previous value for edge detection
      trig_prev_next = trig_sync_reg;
   end

   always_ff @(posedge clk or negedge nrst_s) begin
      if (!nrst_s) begin
         trig_meta_reg <= EBC_TRIG_RST;
         trig_sync_reg <= EBC_TRIG_RST;
         trig_prev_reg <= EBC_TRIG_RST;
      end else begin
         trig_meta_reg <= trig_meta_next;
         trig_sync_reg <= trig_sync_next;
         trig_prev_reg <= trig_prev_next;
      end
   end

   // Edge select and break request sources
   assign trig_edge = trig_rising ? (trig_sync_reg & ~trig_prev_reg)
                                  : (~trig_sync_reg & trig_prev_reg);
   assign trace_event = trig_edge;
   assign async_req   = force_break | (trig_edge & trig_brk_en);
   assign hw_req      = fetch.valid & fetch.bp_hit & ~fetch.skipped;

   // Power-down, watchdog marker and port registers
   always_comb begin
      pd_next   = pd_reg;
      wdt_next  = 1'b0;
      pend_next = pend_reg;
      emu_next  = emu_reg;
      oth_next  = oth_reg;
      // Go clears power-down; a power-off fetch in the same cycle wins
      if (run_cmd) begin
         pd_next = 1'b0;
      end
      if (fetch.valid && !fetch.skipped && state_reg != EBC_HALT) begin
         if (fetch.op == EBC_OP_POWER_OFF) begin
            pd_next = 1'b1;
         end
      end
      // Power-off-arm falls through the decode with no action
      // Marker stays up while the restart instruction still executes
      if (fetch.op == EBC_OP_WDT_RESTART && !fetch.skipped) begin
         wdt_next = fetch.valid | wdt_reg;
      end
      // Emulated port values wait here until the next output instruction; other ports load at once
      if (out_wr) begin
         pend_next = out_wr_data;
         oth_next  = other_wr_data;
      end
      if (fetch.op == EBC_OP_OUTPUT && tstate == EBC_T2) begin
         emu_next = pend_reg;
      end
   end

   // Run control: a pending break halts on a later fetch
   always_comb begin
      state_next  = state_reg;
      halt_next   = halt_reg;
      resume_next = resume_reg;
      case (state_reg)
         EBC_RUN: begin
            if (async_req) begin
               state_next = EBC_PEND_ASYNC;
            end else if (hw_req) begin
               state_next = EBC_PEND_HW;
            end
         end
         EBC_PEND_ASYNC: begin
            // Halts on the next fetch, even inside a continuous run
            if (fetch.valid) begin
               state_next = EBC_HALT;
               halt_next  = fetch.addr;
               resume_next = fetch.addr;
            end
         end
         EBC_PEND_HW: begin
            // Waits until the continuous run has ended
            if (fetch.valid && !fetch.skipped &&
                fetch.op != EBC_OP_CONT) begin
               state_next  = EBC_HALT;
               halt_next   = fetch.addr;
               resume_next = fetch.addr;
            end
         end
         EBC_HALT: begin
            // Host picks the restart address past any run
            if (run_cmd) begin
               state_next = EBC_RUN;
            end
         end
         default: begin
            state_next = EBC_RUN;
         end
      endcase
   end

   // Register all next values
   always_ff @(posedge clk or negedge nrst_s) begin
      if (!nrst_s) begin
         state_reg   <= EBC_RUN;
         halt_reg    <= '0;
         resume_reg  <= '0;
         pd_reg      <= 1'b0;
         wdt_reg     <= 1'b0;
         pend_reg    <= '{p0: EBC_P0_RST, p1: EBC_P1_RST, d: EBC_D_RST};
         emu_reg     <= '{p0: EBC_P0_RST, p1: EBC_P1_RST, d: EBC_D_RST};
         oth_reg     <= 4'h0;
      end else begin
         state_reg   <= state_next;
         halt_reg    <= halt_next;
         resume_reg  <= resume_next;
         pd_reg      <= pd_next;
         wdt_reg     <= wdt_next;
         pend_reg    <= pend_next;
         emu_reg     <= emu_next;
         oth_reg     <= oth_next;
      end
   end

   // Outputs are decoded from the registers; timer_clk_en is tied high
   assign halted             = (state_reg == EBC_HALT);
   assign halt_addr          = halt_reg;
   assign resume_addr        = resume_reg;
   assign core_run           = (state_reg != EBC_HALT) & ~pd_reg;
   assign timer_clk_en       = 1'b1;
   assign power_down         = pd_reg;
   assign watchdog_check_pin = wdt_reg;
   assign emu_ports          = emu_reg;
   assign other_ports        = oth_reg;

endmodule

// ===== src/ebc_pkg.sv
// Shared types and constants of the emulator break control block.
// Assumes one system clock and a fetch stream reported by the core.
package ebc_pkg;

   localparam int          EBC_ADDR_W      = 13;
   localparam int          EBC_P0_W        = 4;
   localparam int          EBC_P1_W        = 4;
   localparam int          EBC_D_W         = 6;
   localparam logic [3:0]  EBC_P0_RST      = 4'h0;
   localparam logic [3:0]  EBC_P1_RST      = 4'h0;
   localparam logic [5:0]  EBC_D_RST       = 6'h00;
   localparam logic        EBC_TRIG_RST    = 1'b0;
   localparam logic [1:0]  EBC_T1          = 2'h0;
   localparam logic [1:0]  EBC_T2          = 2'h1;
   localparam logic [1:0]  EBC_T3          = 2'h2;

   // Instruction classes decoded by the core for this block
   typedef enum logic [2:0] {
      EBC_OP_OTHER,
      EBC_OP_CONT,
      EBC_OP_OUTPUT,
      EBC_OP_POWER_OFF,
      EBC_OP_POWER_ARM,
      EBC_OP_WDT_RESTART
   } ebc_op_t;

   // One fetched instruction as seen by the block
   typedef struct packed {
      logic                  valid;
      logic [EBC_ADDR_W-1:0] addr;
      ebc_op_t               op;
      logic                  skipped;
      logic                  bp_hit;
   } ebc_fetch_t;

   // Emulated port values
   typedef struct packed {
      logic [EBC_P0_W-1:0] p0;
      logic [EBC_P1_W-1:0] p1;
      logic [EBC_D_W-1:0]  d;
   } ebc_ports_t;

endpackage
